// ==== src/ldcr_map.svh ====
/*
  register offsets, field positions, reset values and masks of the line
  driver control and diagnostic register bank.
  assumes: included by bare name from the package and the design file.
*/
`ifndef LDCR_MAP_SVH
`define LDCR_MAP_SVH

// register offsets
`define LDCR_OFS_CONFIG 8'h00
`define LDCR_OFS_RETRY 8'h01
`define LDCR_OFS_GENFLT 8'h02
`define LDCR_OFS_LEFTFLT 8'h03
`define LDCR_OFS_RIGHTFLT 8'h04
`define LDCR_OFS_FLAGS 8'h05
`define LDCR_OFS_GEN 8'h06
`define LDCR_OFS_LEN 8'h07
`define LDCR_OFS_REN 8'h08

// configuration fields
`define LDCR_CFG_DIAGON 7
`define LDCR_CFG_ENABLE 6
`define LDCR_CFG_MUTE 5
`define LDCR_CFG_PUMPOFF 4
`define LDCR_CFG_OLL 3
`define LDCR_CFG_OLR 2

// retry command fields
`define LDCR_CMD_LRETRY 7
`define LDCR_CMD_RRETRY 6

// general fault fields
`define LDCR_GF_WARN 6
`define LDCR_GF_TSHUT 5
`define LDCR_GF_OVV 4
`define LDCR_GF_MASK 8'h70

// channel fault fields
`define LDCR_CF_SUP 7
`define LDCR_CF_GND 6
`define LDCR_CF_LIM 5
`define LDCR_CF_OFS 3
`define LDCR_CF_OPEN 2
`define LDCR_CF_MASK 8'hec

// flag register fields
`define LDCR_FL_FAULT 7
`define LDCR_FL_LHIZ 6
`define LDCR_FL_RHIZ 5
`define LDCR_FL_LOFS 4
`define LDCR_FL_ROFS 3

// reset values
`define LDCR_RST_BYTE 8'h00

`endif

// ==== src/ldcr_pkg.sv ====
/*
  types shared by the line driver control and diagnostic register bank.
  assumes: field positions come from ldcr_map.svh.
*/
`include "ldcr_map.svh"

package ldcr_pkg;
  // one register byte
  typedef logic [7:0] ldcr_byte_t;
  // charge pump frequency codes
  typedef enum logic [1:0] {
    LDCR_PUMP_333K = 2'h0,
    LDCR_PUMP_190K = 2'h1,
    LDCR_PUMP_426K = 2'h2,
    LDCR_PUMP_260K = 2'h3
  } ldcr_pump_e;
  // per channel amplifier state, one-hot
  typedef enum logic [1:0] {
    LDCR_AMP_ON = 2'b01,
    LDCR_AMP_OFF = 2'b10
  } ldcr_amp_e;
endpackage

// ==== src/ldcr_regs.sv ====
/*
  control and diagnostic register bank of a dual-channel line driver:
  configuration, retry command, masked fault capture, clear-on-read
  channel faults, summary flags and the open-drain fault output.
  assumes: the serial transport delivers one-cycle write and read strobes
  with an 8-bit address and data on clock_i; analog detectors give levels
  from outside the clock domain.
  the fault pin is open drain: fault_pin_o is its data, always low, and
  fault_pin_oe_o switches the pad driver on while a fault is held.
  a read and a write in the same cycle both act; the transport keeps
  them apart if it needs a defined order on one register.
*/
// Summary of operation
// - config bit 7 turns diagnostic mode on
// - config bit 6 enables; pin low disables
// - config bit 5 mutes; mute pin forces
// - config bit 4 switches charge pump off
// - bits 3/2 rising start one open-load test
// - config bits 1:0 pick pump frequency
// - shorted amplifier off until retry bit written
// - general faults: warning, shutdown, overvoltage
// - general faults gated by enable register
// - left fault bits 7,6,5,3,2
// - right fault bits same as left
// - channel faults gated by channel enable
// - fault pin low on any channel fault
// - flag bit 7 mirrors fault pin low
// - flag bits 6/5 report floating outputs
// - flag bits 4/3 report channel offset
// - flag bits 2:0 give variant code
// - reading channel fault register clears it
// - enabled short switches channel off, floating
`timescale 1ns/10ps

`include "ldcr_map.svh"

module ldcr_regs #(
  parameter logic [2:0] VARIANT_CODE = 3'h2 // arbitrary value
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic power_down_pin_n_i,
  input wire logic mute_pin_n_i,
  input wire logic [2:0] gen_fault_raw_i,
  input wire logic [4:0] left_fault_raw_i,
  input wire logic [4:0] right_fault_raw_i,
  output logic diagnostic_mode_on_o,
  output logic device_enabled_o,
  output logic outputs_muted_o,
  output logic pump_disable_o,
  output logic [1:0] pump_freq_sel_o,
  output logic left_openload_start_o,
  output logic right_openload_start_o,
  output logic left_amp_on_o,
  output logic right_amp_on_o,
  output logic left_output_floating_o,
  output logic right_output_floating_o,
  output logic fault_pin_o,
  output logic fault_pin_oe_o
);

  // every level from outside the clock domain goes through one common
  // filter, so detectors and pins see the same latency
  // raw inputs packed: [12:8] right, [7:3] left, [2:0] general, [14:13] pins
  localparam int NIN = 15;

  // three-stage synchronisers per input bit
  // only b reads a; filt compares b with c
  logic [NIN-1:0] sync_a;
  logic [NIN-1:0] sync_b;
  logic [NIN-1:0] sync_c;
  logic [NIN-1:0] filt; // filtered level, changes when b and c agree
  logic [NIN-1:0] raw_all;

  // register bytes, synchronously reset to zero, then 2-bit pulse, edge and state flops; the states reset to LDCR_AMP_ON
  // the variant code is a parameter and never stored
  ldcr_pkg::ldcr_byte_t config_reg; // control bits
  ldcr_pkg::ldcr_byte_t gen_fault_reg;
  ldcr_pkg::ldcr_byte_t left_fault_reg;
  ldcr_pkg::ldcr_byte_t right_fault_reg;
  ldcr_pkg::ldcr_byte_t general_enable_reg;
  ldcr_pkg::ldcr_byte_t left_enable_reg;
  ldcr_pkg::ldcr_byte_t right_enable_reg;
  logic [1:0] retry_pulse; // [1] left, [0] right, one cycle
  logic [1:0] old_prev; // previous open-load start bits
  ldcr_pkg::ldcr_amp_e left_state;
  ldcr_pkg::ldcr_amp_e right_state;

  // decoded faults in register layout
  // already gated by diagnostic mode and the enable registers
  ldcr_pkg::ldcr_byte_t left_det;
  ldcr_pkg::ldcr_byte_t right_det;
  ldcr_pkg::ldcr_byte_t gen_det;
  logic fault_any;
  logic left_short;
  logic right_short;
  logic wr_cfg;

  assign raw_all = {mute_pin_n_i, power_down_pin_n_i, right_fault_raw_i,
                    left_fault_raw_i, gen_fault_raw_i};

  // synchroniser chain, three flop stages per bit
  // every stage resets to the idle level of its input, so the first
  // compare after reset agrees at idle and no false edge follows
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
          sync_a[gi] <= (gi >= 13); // pins idle high, detectors idle low
          sync_b[gi] <= (gi >= 13);
          sync_c[gi] <= (gi >= 13);
          filt[gi] <= (gi >= 13); // filtered level starts at idle too
        end else begin
          sync_a[gi] <= raw_all[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
          if (sync_b[gi] == sync_c[gi]) begin // agree: accept
            filt[gi] <= sync_c[gi];
          end
        end
      end
    end
  endgenerate

  // map raw detector bits into register positions
  // bits 4, 1 and 0 of the register stay zero
  function automatic ldcr_pkg::ldcr_byte_t chan_map(input logic [4:0] r);
    ldcr_pkg::ldcr_byte_t v;
    v = 8'h00;
    v[`LDCR_CF_SUP] = r[4];
    v[`LDCR_CF_GND] = r[3];
    v[`LDCR_CF_LIM] = r[2];
    v[`LDCR_CF_OFS] = r[1];
    v[`LDCR_CF_OPEN] = r[0];
    return v;
  endfunction

  // detection only in diagnostic mode and when enabled
  // a masked detector never reaches a register, the pin or a channel state
  // general bits: [2] warning to bit 6, [1] shutdown to 5, [0] overvoltage to 4
  always_comb begin
    left_det = chan_map(filt[7:3]) & left_enable_reg &
               {8{config_reg[`LDCR_CFG_DIAGON]}};
    right_det = chan_map(filt[12:8]) & right_enable_reg &
                {8{config_reg[`LDCR_CFG_DIAGON]}};
    gen_det = {1'b0, filt[2:0], 4'h0} & general_enable_reg &
              {8{config_reg[`LDCR_CFG_DIAGON]}};
  end

  // only supply and ground shorts switch a channel off
  // overcurrent, offset and open load only report
  assign left_short = left_det[`LDCR_CF_SUP] | left_det[`LDCR_CF_GND];
  assign right_short = right_det[`LDCR_CF_SUP] | right_det[`LDCR_CF_GND];
  assign wr_cfg = wr_stb_i && (addr_i == `LDCR_OFS_CONFIG);

  // configuration register
  // plain storage, nothing in it self-clears
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      config_reg <= `LDCR_RST_BYTE;
    end else if (wr_cfg) begin
      config_reg <= wdata_i;
    end
  end

  // open-load start: rising edge of config bits 3/2 gives one pulse
  // a repeated one is ignored; a zero must be written in between
  // the pulse comes one clock after the stored bit rises
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      old_prev <= 2'h0;
      left_openload_start_o <= 1'b0;
      right_openload_start_o <= 1'b0;
    end else begin
      old_prev <= {config_reg[`LDCR_CFG_OLL], config_reg[`LDCR_CFG_OLR]};
      left_openload_start_o <= config_reg[`LDCR_CFG_OLL] & ~old_prev[1];
      right_openload_start_o <= config_reg[`LDCR_CFG_OLR] & ~old_prev[0];
    end
  end

  // retry command: one-cycle pulse, never stored
  // so the command byte reads zero and cannot fire twice
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      retry_pulse <= 2'h0;
    end else if (wr_stb_i && (addr_i == `LDCR_OFS_RETRY)) begin
      retry_pulse <= {wdata_i[`LDCR_CMD_LRETRY], wdata_i[`LDCR_CMD_RRETRY]};
    end else begin
      retry_pulse <= 2'h0;
    end
  end

  // mask registers, unused bits held at zero
  // right enable sits after the left one, same layout
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      general_enable_reg <= `LDCR_RST_BYTE;
      left_enable_reg <= `LDCR_RST_BYTE;
      right_enable_reg <= `LDCR_RST_BYTE;
    end else if (wr_stb_i) begin
      case (addr_i)
        `LDCR_OFS_GEN: general_enable_reg <= wdata_i & `LDCR_GF_MASK;
        `LDCR_OFS_LEN: left_enable_reg <= wdata_i & `LDCR_CF_MASK;
        `LDCR_OFS_REN: right_enable_reg <= wdata_i & `LDCR_CF_MASK;
        default: ;
      endcase
    end
  end

  // general faults track the masked detectors
  // no latch: a bit drops with its level, reads have no side effect
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      gen_fault_reg <= `LDCR_RST_BYTE;
    end else begin
      gen_fault_reg <= gen_det;
    end
  end

  // channel faults sticky, cleared on read, a new set wins over the clear
  // a condition still present at the clearing read shows again at once,
  // so the host never loses a fault between two reads
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      left_fault_reg <= `LDCR_RST_BYTE;
    end else if (rd_stb_i && (addr_i == `LDCR_OFS_LEFTFLT)) begin
      left_fault_reg <= left_det;
    end else begin
      left_fault_reg <= left_fault_reg | left_det;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      right_fault_reg <= `LDCR_RST_BYTE;
    end else if (rd_stb_i && (addr_i == `LDCR_OFS_RIGHTFLT)) begin
      right_fault_reg <= right_det;
    end else begin
      right_fault_reg <= right_fault_reg | right_det;
    end
  end

  // left amplifier: off on a short until retried
  // a retry while the short is still seen trips it again next cycle
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      left_state <= ldcr_pkg::LDCR_AMP_ON;
    end else begin
      case (left_state)
        ldcr_pkg::LDCR_AMP_ON: if (left_short) begin
          left_state <= ldcr_pkg::LDCR_AMP_OFF;
        end
        ldcr_pkg::LDCR_AMP_OFF: if (retry_pulse[1]) begin
          left_state <= ldcr_pkg::LDCR_AMP_ON;
        end
        default: left_state <= ldcr_pkg::LDCR_AMP_ON;
      endcase
    end
  end

  // right amplifier: same sequence
  // its retry is bit 6 of the command byte
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      right_state <= ldcr_pkg::LDCR_AMP_ON;
    end else begin
      case (right_state)
        ldcr_pkg::LDCR_AMP_ON: if (right_short) begin
          right_state <= ldcr_pkg::LDCR_AMP_OFF;
        end
        ldcr_pkg::LDCR_AMP_OFF: if (retry_pulse[0]) begin
          right_state <= ldcr_pkg::LDCR_AMP_ON;
        end
        default: right_state <= ldcr_pkg::LDCR_AMP_ON;
      endcase
    end
  end

  // general faults report through their register only, not the pin
  assign fault_any = (|left_fault_reg) | (|right_fault_reg);

  // control outputs, registered
  // one cycle behind the register bits; pins already filtered
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      diagnostic_mode_on_o <= 1'b0;
      device_enabled_o <= 1'b0;
      outputs_muted_o <= 1'b0;
      pump_disable_o <= 1'b0;
      pump_freq_sel_o <= 2'h0;
      left_amp_on_o <= 1'b0;
      right_amp_on_o <= 1'b0;
      left_output_floating_o <= 1'b0;
      right_output_floating_o <= 1'b0;
      fault_pin_oe_o <= 1'b0;
    end else begin
      diagnostic_mode_on_o <= config_reg[`LDCR_CFG_DIAGON];
      device_enabled_o <= config_reg[`LDCR_CFG_ENABLE] & filt[13];
      outputs_muted_o <= config_reg[`LDCR_CFG_MUTE] | ~filt[14];
      pump_disable_o <= config_reg[`LDCR_CFG_PUMPOFF];
      pump_freq_sel_o <= config_reg[1:0];
      left_amp_on_o <= (left_state == ldcr_pkg::LDCR_AMP_ON);
      right_amp_on_o <= (right_state == ldcr_pkg::LDCR_AMP_ON);
      left_output_floating_o <= (left_state == ldcr_pkg::LDCR_AMP_OFF);
      right_output_floating_o <= (right_state == ldcr_pkg::LDCR_AMP_OFF);
      fault_pin_oe_o <= fault_any;
    end
  end

  // open drain: only ever drives low
  // the pad pulls low while the enable is high, floats otherwise
  assign fault_pin_o = 1'b0;

  // read data, registered; unmapped offsets read zero
  // a clearing read returns the contents held before the same edge
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_stb_i) begin
      case (addr_i)
        `LDCR_OFS_CONFIG: rdata_o <= config_reg;
        `LDCR_OFS_RETRY: rdata_o <= 8'h00;
        `LDCR_OFS_GENFLT: rdata_o <= gen_fault_reg;
        `LDCR_OFS_LEFTFLT: rdata_o <= left_fault_reg;
        `LDCR_OFS_RIGHTFLT: rdata_o <= right_fault_reg;
        `LDCR_OFS_FLAGS: rdata_o <= {fault_pin_oe_o,
                                      left_output_floating_o,
                                      right_output_floating_o,
                                      left_fault_reg[`LDCR_CF_OFS],
                                      right_fault_reg[`LDCR_CF_OFS],
                                      VARIANT_CODE};
        `LDCR_OFS_GEN: rdata_o <= general_enable_reg;
        `LDCR_OFS_LEN: rdata_o <= left_enable_reg;
        `LDCR_OFS_REN: rdata_o <= right_enable_reg;
        default: rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// ==== testbench/ldcr_chk.sv ====
/* port checker for the line driver register bank.
   assumes: bound onto ldcr_regs, one clock, sync active-low reset. */
`timescale 1ns/10ps
module ldcr_chk #(
  parameter logic [2:0] VARIANT_CODE = 3'h2 // arbitrary value
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic power_down_pin_n_i,
  input wire logic mute_pin_n_i,
  input wire logic diagnostic_mode_on_o,
  input wire logic device_enabled_o,
  input wire logic outputs_muted_o,
  input wire logic [1:0] pump_freq_sel_o,
  input wire logic left_openload_start_o,
  input wire logic left_amp_on_o,
  input wire logic left_output_floating_o,
  input wire logic fault_pin_o,
  input wire logic fault_pin_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // config write shows two edges later
  a_diagnostic_follows_write: assert property (wr_stb_i && addr_i == 8'h00 |-> ##2
    diagnostic_mode_on_o == $past(wdata_i[7], 2)) else $error("diagnostic mode mismatch");
  a_pump_freq_write: assert property (wr_stb_i && addr_i == 8'h00 |-> ##2
    pump_freq_sel_o == $past(wdata_i[1:0], 2)) else $error("pump freq mismatch");
  a_pin_forces_off: assert property (!power_down_pin_n_i [*8] |->
    !device_enabled_o) else $error("enable not forced off");
  a_pin_forces_mute: assert property (!mute_pin_n_i [*8] |->
    outputs_muted_o) else $error("mute not forced");
  a_openload_one_pulse: assert property (left_openload_start_o |=>
    !left_openload_start_o) else $error("open load start too long");
  a_float_means_off: assert property (left_output_floating_o |->
    !left_amp_on_o) else $error("floating channel still on");
  a_flag_summary: assert property (rd_stb_i && addr_i == 8'h05 |=>
    rdata_o[7] == $past(fault_pin_oe_o) && rdata_o[2:0] == VARIANT_CODE)
    else $error("flag byte mismatch");
  a_fault_pin_low: assert property (fault_pin_o == 1'b0)
    else $error("fault pin data not low");
  a_unused_read_zero: assert property (rd_stb_i && (addr_i > 8'h08 || addr_i == 8'h01)
    |=> rdata_o == 8'h00) else $error("unused read not zero");
  a_rdata_holds: assert property (!rd_stb_i |=> $stable(rdata_o))
    else $error("read data moved");
endmodule
bind ldcr_regs ldcr_chk #(.VARIANT_CODE(VARIANT_CODE)) i_ldcr_chk (.clock_i, .rstn_i,
  .wr_stb_i, .rd_stb_i, .addr_i, .wdata_i, .rdata_o, .power_down_pin_n_i, .mute_pin_n_i,
  .diagnostic_mode_on_o, .device_enabled_o, .outputs_muted_o, .pump_freq_sel_o,
  .left_openload_start_o, .left_amp_on_o, .left_output_floating_o, .fault_pin_o,
  .fault_pin_oe_o);

// ==== testbench/ldcr_host.sv ====
/* host model: single-byte register writes and reads on the strobe bus.
   assumes: strobe taken at a rising edge, read data valid one cycle on. */
`timescale 1ns/10ps
module ldcr_host (
  input wire logic clock_i,
  output logic wr_stb_o,
  output logic rd_stb_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  // idle bus at time zero
  initial begin
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // one write; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) #1;
    wr_stb_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge clock_i) #1;
    wr_stb_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // one read; data taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i) #1;
    rd_stb_o = 1'b1;
    addr_o = a;
    @(posedge clock_i) #1;
    rd_stb_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule

// ==== testbench/tb_ldcr_regs.sv ====
/* self-checking bench of the register bank.
   assumes: host model drives the bus, bench drives pins and detectors. */
`timescale 1ns/10ps
module tb_ldcr_regs;
  localparam logic [2:0] VC = 3'h3; // arbitrary variant code
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wr, rd, pdn = 1'b1, mute = 1'b1;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] graw = 3'h0;
  logic [4:0] lraw = 5'h00, rraw = 5'h00;
  logic dg, en, mu, pd, lo, ro, la, ra, lf, rf, fp, oe;
  logic [1:0] fs;
  int n_mismatch = 0, compares = 0, nol = 0, nor_ = 0;
  wire logic [7:0] st = {dg, en, mu, pd, fs, la, lf};
  wire logic [7:0] st2 = {4'h0, ra, rf, oe, fp};
  always #5 clock_i = ~clock_i;
  // count open-load start pulses
  always @(posedge clock_i) begin
    nol += int'(lo);
    nor_ += int'(ro);
  end
  ldcr_host i_ldcr_host (.clock_i(clock_i), .wr_stb_o(wr), .rd_stb_o(rd), .addr_o(addr),
    .wdata_o(wdata), .rdata_i(rdata));
  ldcr_regs #(.VARIANT_CODE(VC)) i_ldcr_regs (.clock_i(clock_i), .rstn_i(rstn_i),
    .wr_stb_i(wr), .rd_stb_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .power_down_pin_n_i(pdn), .mute_pin_n_i(mute), .gen_fault_raw_i(graw),
    .left_fault_raw_i(lraw), .right_fault_raw_i(rraw), .diagnostic_mode_on_o(dg),
    .device_enabled_o(en), .outputs_muted_o(mu), .pump_disable_o(pd), .pump_freq_sel_o(fs),
    .left_openload_start_o(lo), .right_openload_start_o(ro), .left_amp_on_o(la),
    .right_amp_on_o(ra), .left_output_floating_o(lf), .right_output_floating_o(rf),
    .fault_pin_o(fp), .fault_pin_oe_o(oe));
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write, then let the outputs settle one edge
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_ldcr_host.wr(a, d);
    @(posedge clock_i) #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_ldcr_host.rd(a, d);
    cmp($sformatf("reg %h", a), e, d);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic end_sim();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // reset values, unmapped read
  task automatic t_reset();
    for (int a = 0; a < 10; a++) rc(8'(a), (a == 5) ? {5'h0, VC} : 8'h00);
    cmp("st", 8'h02, st);
  endtask
  // config fields, pump codes, open-load restart
  task automatic t_cfg();
    w(8'h00, 8'hfc);
    rc(8'h00, 8'hfc);
    cmp("st", 8'hf2, st);
    for (int i = 0; i < 4; i++) begin
      w(8'h00, 8'(i));
      cmp("st", {4'h0, 2'(i), 2'b10}, st);
    end
    w(8'h00, 8'h08);
    w(8'h00, 8'h08);
    cmp("ol", 8'h02, 8'(nol));
    cmp("or", 8'h01, 8'(nor_));
  endtask
  // pin overrides
  task automatic t_pins();
    w(8'h00, 8'h40);
    pdn = 1'b0;
    mute = 1'b0;
    waitc(8);
    cmp("st", 8'h22, st);
    pdn = 1'b1;
    mute = 1'b1;
    waitc(8);
    cmp("st", 8'h42, st);
  endtask
  // read-only and unused bits
  task automatic t_masks();
    logic [7:0] ad[6] = '{8'h06, 8'h07, 8'h08, 8'h01, 8'h02, 8'h05};
    logic [7:0] ex[6] = '{8'h70, 8'hec, 8'hec, 8'h00, 8'h00, {5'h0, VC}};
    for (int i = 0; i < 6; i++) begin
      w(ad[i], 8'hff);
      rc(ad[i], ex[i]);
    end
  endtask
  // left short, clear on read, retry
  task automatic t_short();
    w(8'h00, 8'hc0);
    lraw = 5'h10;
    waitc(8);
    cmp("st", 8'hc1, st);
    cmp("st2", 8'h0a, st2);
    rc(8'h05, {5'h18, VC});
    rc(8'h03, 8'h80);
    lraw = 5'h00;
    waitc(8);
    rc(8'h03, 8'h80);
    rc(8'h03, 8'h00);
    cmp("st2", 8'h08, st2);
    w(8'h01, 8'h80);
    waitc(3);
    cmp("st", 8'hc2, st);
    rc(8'h05, {5'h0, VC});
  endtask
  // right and general masking, offset flag
  task automatic t_right();
    w(8'h08, 8'h08);
    w(8'h06, 8'h20);
    rraw = 5'h1f;
    graw = 3'h7;
    waitc(8);
    rc(8'h04, 8'h08);
    rc(8'h02, 8'h20);
    rc(8'h05, {5'h11, VC});
    rraw = 5'h00;
    graw = 3'h0;
    waitc(8);
    rc(8'h04, 8'h08);
    rc(8'h04, 8'h00);
    rc(8'h02, 8'h00);
    cmp("st2", 8'h08, st2);
  endtask
  // right ground short, clear on read, right retry
  task automatic t_rshort();
    w(8'h08, 8'h40);
    rraw = 5'h08;
    waitc(8);
    cmp("st2", 8'h06, st2);
    rc(8'h05, {5'h14, VC});
    rraw = 5'h00;
    waitc(8);
    rc(8'h04, 8'h40);
    rc(8'h04, 8'h00);
    w(8'h01, 8'h40);
    waitc(3);
    cmp("st2", 8'h08, st2);
  endtask
  // mid-run reset: idle pins must not look asserted afterwards
  task automatic t_rerst();
    w(8'h00, 8'h40);
    rstn_i = 1'b0;
    waitc(2);
    rstn_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      waitc(1);
      cmp("st", 8'h02, st);
    end
    rc(8'h00, 8'h00);
  endtask
  initial begin
    #50us;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    t_reset();
    t_cfg();
    t_pins();
    t_masks();
    t_short();
    t_right();
    t_rshort();
    t_rerst();
    end_sim();
  end
endmodule
